/* ipe_pkg.sv */
// Constants for the interrupt poll and end-of-interrupt unit
package ipe_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int SLOT_N = 8;
	localparam int SLOT_W = 3;
	localparam int TYPE_W = 8;
	localparam int VT_W = 5;
	localparam int SYNC_N = 5;
	// Register offsets in the peripheral block
	localparam logic [7:0] OFS_VECTOR_BASE = 8'h20;
	localparam logic [7:0] OFS_END_OF_INTERRUPT = 8'h22;
	localparam logic [7:0] OFS_POLL_ACKNOWLEDGE = 8'h24;
	localparam logic [7:0] OFS_POLL_PEEK = 8'h26;
	localparam logic [7:0] OFS_SOURCE_MASK = 8'h28;
	localparam logic [7:0] OFS_IN_SERVICE = 8'h2c;
	localparam logic [7:0] OFS_REQUEST = 8'h2e;
	localparam logic [7:0] OFS_SHARED_STATUS = 8'h30;
	// Field positions
	localparam int PEND_BIT = 15;
	localparam int NONSPECIFIC_SELECT_BIT = 15;
	localparam int DMA_STOP_BIT = 15;
	localparam int VBASE_LSB = 3;
	// Slots: lower index is higher priority
	localparam int SLOT_TMR0 = 0;
	localparam int SLOT_TMR1 = 4;
	localparam int SLOT_TMR2 = 5;
	localparam logic [7:0] SLOT_OK_MASTER = 8'hfd;
	localparam logic [7:0] SLOT_OK_SLAVE = 8'h3d;
	localparam logic [3:0] SLOT_NONE = 4'h8;
	// Fixed master types start at the shared timer type
	localparam logic [TYPE_W-1:0] MASTER_TYPE_BASE = 8'h08;
	localparam logic [1:0] MASTER_VT_HIGH = 2'h1;
	// Reset values
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [2:0] ZERO3 = 3'h0;
	localparam logic [4:0] VBASE_RESET = 5'h00;
	localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;
endpackage : ipe_pkg

/* ipe_unit.sv */
// Interrupt poll, poll peek, end-of-interrupt and shared timer status logic
//
// What this block does
// - Pending flag and highest-priority 5-bit type shown in both poll registers.
// - Poll read acknowledges like CPU vectoring, without external cycle or vector fetch.
// - Poll read updates request, in-service and poll state as a normal acknowledge.
// - Poll peek read returns the same content and changes nothing.
// - Non-specific end-of-interrupt clears the highest-priority in-service bit.
// - Specific end-of-interrupt clears only the in-service bit of the written type.
// - Timers share one in-service bit, cleared by a specific command with type 8.
// - Three timers share one source; per-timer pending bits may set together.
// - Per-timer pending bits clear when the shared timer request is acknowledged.
// - DMA stop bit blocks all DMA activity while set; resets to zero.
// - In slave mode the unit acts as a cascaded slave of an external master.
// - In slave mode each timer is its own source with new bit positions.
// - Slave mode adds exactly one register, the vector base register.
// - In-service bit sets on acknowledge, holds until end-of-interrupt, drives nesting.
// - Request bit sets on every event, masked or not, and clears on acknowledge.
// - Slave mode accepts only specific end-of-interrupt; no poll or poll peek.
`timescale 1ns/100ps
module ipe_unit (
	input wire logic core_clk, // 200 MHz core clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic reg_sel, // Peripheral block select
	input wire logic reg_rd, // Read strobe
	input wire logic reg_wr, // Write strobe
	input wire logic [ipe_pkg::ADDR_W-1:0] reg_addr, // Register offset
	input wire logic [ipe_pkg::DATA_W-1:0] reg_wdata, // Write data
	input wire logic [3:0] ext_int_pin, // External request pins, rising edge
	input wire logic slave_mode_pin, // Strap selecting slave mode
	input wire logic [2:0] tmr_req, // Timer request pulses
	input wire logic [1:0] dma_req, // DMA channel request pulses
	input wire logic cpu_ack, // CPU or master acknowledge pulse
	// Read data is registered, so a read answers one cycle after its strobe
	// and falls back to zero unless another read follows
	output logic [ipe_pkg::DATA_W-1:0] reg_rdata, // Read data, one cycle after strobe
	output logic cpu_irq, // Interrupt request to CPU or master
	output logic [ipe_pkg::TYPE_W-1:0] ack_type, // Type of the last acknowledge
	output logic ack_valid, // Pulse: an acknowledge was taken
	output logic dma_stop // Blocks DMA activity
);
	function automatic logic [3:0] first_set(input logic [7:0] v);
		logic [3:0] idx;
		idx = ipe_pkg::SLOT_NONE;
		for (int i = ipe_pkg::SLOT_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : first_set

	function automatic logic [7:0] one_hot(input logic [2:0] s);
		return 8'h01 << s;
	endfunction : one_hot

	// Pins cross into the clock domain through three flip-flops
	logic [ipe_pkg::SYNC_N-1:0] sync1_r, sync2_r, sync3_r, lvl_r;
	logic [ipe_pkg::SLOT_N-1:0] req_r, isr_r, mask_r;
	logic [2:0] tstat_r;
	logic stop_r;
	logic [4:0] vbase_r;
	logic [ipe_pkg::DATA_W-1:0] rdata_r;
	logic irq_r, ackv_r;
	logic [ipe_pkg::TYPE_W-1:0] ackt_r;

	// The strap sits above the four request pins in every chain vector
	wire [ipe_pkg::SYNC_N-1:0] pin_raw = {slave_mode_pin, ext_int_pin};
	// A level counts only once stages two and three agree, which filters a
	// single-cycle glitch that slips past the first stage
	wire [ipe_pkg::SYNC_N-1:0] agree = ~(sync2_r ^ sync3_r);
	wire [ipe_pkg::SYNC_N-1:0] lvl_nxt = (sync3_r & agree) | (lvl_r & ~agree);
	wire [3:0] ext_rise = lvl_nxt[3:0] & ~lvl_r[3:0];
	wire slave = lvl_r[4];

	wire rd_go = ce & reg_sel & reg_rd;
	wire wr_go = ce & reg_sel & reg_wr;
	wire a_vbase = reg_addr == ipe_pkg::OFS_VECTOR_BASE;
	wire a_eoi = reg_addr == ipe_pkg::OFS_END_OF_INTERRUPT;
	wire a_poll = reg_addr == ipe_pkg::OFS_POLL_ACKNOWLEDGE;
	wire a_peek = reg_addr == ipe_pkg::OFS_POLL_PEEK;
	wire a_mask = reg_addr == ipe_pkg::OFS_SOURCE_MASK;
	wire a_isr = reg_addr == ipe_pkg::OFS_IN_SERVICE;
	wire a_req = reg_addr == ipe_pkg::OFS_REQUEST;
	wire a_stat = reg_addr == ipe_pkg::OFS_SHARED_STATUS;

	// Source layout depends on mode
	// Master: slot 0 is the shared timer source, slot 1 is unused,
	// slots 2 and 3 are the DMA channels and slots 4 to 7 the pins.
	// Slave: the timers split into slots 0, 4 and 5 and the pins drop out,
	// so a strap change can strand bits that the new layout never clears;
	// the strap is meant to be fixed before software starts.
	wire [7:0] slot_ok = slave ? ipe_pkg::SLOT_OK_SLAVE : ipe_pkg::SLOT_OK_MASTER;
	wire [7:0] set_master = {ext_rise, dma_req, 1'b0, |tmr_req};
	wire [7:0] set_slave = {2'b00, tmr_req[2], tmr_req[1], dma_req, 1'b0, tmr_req[0]};
	wire [7:0] req_set = (slave ? set_slave : set_master) & slot_ok;

	// Candidate must outrank every in-service source, which gives nesting
	wire [3:0] cand = first_set(req_r & ~mask_r & slot_ok);
	wire [3:0] top = first_set(isr_r);
	wire pend = cand < top;
	wire [4:0] master_vt = 5'(ipe_pkg::MASTER_TYPE_BASE) + {2'b00, cand[2:0]};
	wire [ipe_pkg::TYPE_W-1:0] type_now = slave ? {vbase_r, cand[2:0]} : {3'b000, master_vt};
	wire [ipe_pkg::DATA_W-1:0] poll_word = pend ?
		{1'b1, 10'h000, type_now[ipe_pkg::VT_W-1:0]} : ipe_pkg::ZERO16;

	// Poll read acknowledges exactly as the vectoring path does
	wire poll_rd = rd_go & a_poll & ~slave;
	wire ack_go = ce & (cpu_ack | poll_rd) & pend;
	wire [7:0] ack_oh = ack_go ? one_hot(cand[2:0]) : ipe_pkg::ZERO8;

	// End-of-interrupt decode, command only, nothing stored
	wire eoi_go = wr_go & a_eoi;
	wire nonspecific_select = reg_wdata[ipe_pkg::NONSPECIFIC_SELECT_BIT];
	wire ns_ok = nonspecific_select & ~slave & (top != ipe_pkg::SLOT_NONE);
	wire sp_ok = ~nonspecific_select & (slave | (reg_wdata[4:3] == ipe_pkg::MASTER_VT_HIGH));
	wire [2:0] eoi_slot = ns_ok ? top[2:0] : reg_wdata[2:0];
	wire [7:0] eoi_clr = (eoi_go & (ns_ok | sp_ok)) ? one_hot(eoi_slot) : ipe_pkg::ZERO8;

	// Timer status clears on the acknowledge of its source
	wire [2:0] tclr_slave = {ack_oh[ipe_pkg::SLOT_TMR2], ack_oh[ipe_pkg::SLOT_TMR1],
		ack_oh[ipe_pkg::SLOT_TMR0]};
	wire [2:0] tclr = slave ? tclr_slave : {3{ack_oh[ipe_pkg::SLOT_TMR0]}};

	// New events win over a clear in the same cycle
	wire [7:0] req_nxt = (req_r & ~ack_oh) | req_set;
	wire [7:0] isr_nxt = (isr_r & ~eoi_clr) | ack_oh;
	wire [2:0] tstat_nxt = (tstat_r & ~tclr) | tmr_req;
	wire [7:0] mask_nxt = (wr_go & a_mask) ? reg_wdata[7:0] : mask_r;
	wire stop_nxt = (wr_go & a_stat) ? reg_wdata[ipe_pkg::DMA_STOP_BIT] : stop_r;
	wire [4:0] vbase_nxt = (wr_go & a_vbase & slave) ?
		reg_wdata[ipe_pkg::VBASE_LSB +: 5] : vbase_r;

	// Peek reads only, poll read shares the same word
	wire [ipe_pkg::DATA_W-1:0] stat_word = {stop_r, 12'h000, tstat_r};
	wire [ipe_pkg::DATA_W-1:0] rd_mux =
		((a_poll | a_peek) & ~slave) ? poll_word :
		(a_vbase & slave) ? {8'h00, vbase_r, 3'b000} :
		a_mask ? {8'h00, mask_r} :
		a_isr ? {8'h00, isr_r} :
		a_req ? {8'h00, req_r} :
		a_stat ? stat_word :
		ipe_pkg::ZERO16;
	wire [ipe_pkg::DATA_W-1:0] rdata_nxt = rd_go ? rd_mux : ipe_pkg::ZERO16;

	// One chain per pin, all alike
	// Pins reset to the low level, so a pin held high through reset gives
	// exactly one rising edge once the chain has filled
	for (genvar p = 0; p < ipe_pkg::SYNC_N; p++) begin : g_pin_sync
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				sync1_r[p] <= 1'b0;
				sync2_r[p] <= 1'b0;
				sync3_r[p] <= 1'b0;
				lvl_r[p] <= 1'b0;
			end else if (ce) begin
				sync1_r[p] <= pin_raw[p];
				sync2_r[p] <= sync1_r[p];
				sync3_r[p] <= sync2_r[p];
				lvl_r[p] <= lvl_nxt[p];
			end
		end
	end

	// Source state; every event path wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			req_r <= ipe_pkg::ZERO8;
			isr_r <= ipe_pkg::ZERO8;
			mask_r <= ipe_pkg::MASK_RESET;
			tstat_r <= ipe_pkg::ZERO3;
			stop_r <= 1'b0;
			vbase_r <= ipe_pkg::VBASE_RESET;
		end else if (ce) begin
			req_r <= req_nxt;
			isr_r <= isr_nxt;
			mask_r <= mask_nxt;
			tstat_r <= tstat_nxt;
			stop_r <= stop_nxt;
			vbase_r <= vbase_nxt;
		end
	end

	// Slave mode raises the same request line toward the external master
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= ipe_pkg::ZERO16;
			irq_r <= 1'b0;
			ackv_r <= 1'b0;
			ackt_r <= '0;
		end else if (ce) begin
			rdata_r <= rdata_nxt;
			irq_r <= pend & ~ack_go;
			ackv_r <= ack_go;
			ackt_r <= ack_go ? type_now : ackt_r;
		end
	end

	assign reg_rdata = rdata_r;
	assign cpu_irq = irq_r;
	assign ack_type = ackt_r;
	assign ack_valid = ackv_r;
	assign dma_stop = stop_r;
endmodule : ipe_unit

/* ipe_unit_asserts.sv */
// Port checks of the poll and end-of-interrupt unit
`timescale 1ns/100ps
module ipe_chk (
	input wire logic core_clk, // clock
	input wire logic nrst, // reset
	input wire logic ce, // enable
	input wire logic reg_sel, // select
	input wire logic reg_rd, // read
	input wire logic reg_wr, // write
	input wire logic [7:0] reg_addr, // offset
	input wire logic [15:0] reg_wdata, // data in
	input wire logic slave_mode_pin, // strap
	input wire logic cpu_ack, // ack in
	input wire logic [15:0] reg_rdata, // data out
	input wire logic cpu_irq, // request
	input wire logic [7:0] ack_type, // type
	input wire logic ack_valid, // ack pulse
	input wire logic dma_stop // dma block
);
	wire rd = ce & reg_sel & reg_rd & !slave_mode_pin;
	wire st = ce & reg_sel & reg_wr & (reg_addr == 8'h30);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	poll_ack_a: assert property (rd && reg_addr == 8'h24 && cpu_irq |=> ack_valid
		&& reg_rdata[15] && reg_rdata[4:0] == ack_type[4:0]) else $error("poll ack lost");
	peek_same_a: assert property (rd && reg_addr == 8'h26 && !cpu_ack |=> !ack_valid
		&& reg_rdata[15] == $past(cpu_irq)) else $error("peek wrong");
	poll_idle_a: assert property (rd && reg_addr == 8'h24 && !cpu_irq && !cpu_ack
		|=> reg_rdata == 16'h0000 && !ack_valid) else $error("idle poll wrong");
	rdata_rest_a: assert property (!(ce && reg_sel && reg_rd) |=> reg_rdata == 16'h0000)
		else $error("read data lingers");
	stop_write_a: assert property (st |=> dma_stop == $past(reg_wdata[15]))
		else $error("dma stop not written");
	stop_hold_a: assert property (!st |=> $stable(dma_stop))
		else $error("dma stop moved");
	type_hold_a: assert property (!ack_valid |-> $stable(ack_type))
		else $error("ack type moved");
	ack_cause_a: assert property (ack_valid |-> $past(cpu_irq))
		else $error("ack without pending");
endmodule : ipe_chk
bind ipe_unit ipe_chk i_ipe_chk (.*);

/* ipe_cpu_model.sv */
// Processor core model taking vectored interrupts while enabled
`timescale 1ns/100ps
module ipe_cpu_model #(parameter int LAT = 3) (
	input wire logic core_clk, // clock
	input wire logic irq_en, // enabled
	input wire logic cpu_irq, // request
	output logic cpu_ack // ack pulse
);
	int wait_cnt = 0;
	initial cpu_ack = 1'b0;
	// Pause after each ack so the request drop is seen first
	always @(negedge core_clk) begin
		cpu_ack <= (cpu_ack || wait_cnt > 0) ? 1'b0 : irq_en & cpu_irq;
		wait_cnt <= cpu_ack ? LAT : (wait_cnt > 0 ? wait_cnt - 1 : 0);
	end
endmodule : ipe_cpu_model

/* tb_ipe_unit.sv */
// Bench for the poll and end-of-interrupt unit
`timescale 1ns/100ps
module tb_ipe_unit;
	logic core_clk = 1'b0, nrst = 1'b0, sel = 1'b0, rd = 1'b0, wr = 1'b0, irq_en = 1'b0;
	logic slv = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [4:0] evt = 5'h00;
	logic [15:0] rdata;
	logic [7:0] ack_type;
	logic cpu_irq, cpu_ack, ack_valid, dma_stop;
	int err_count = 0, total_checks = 0, cyc = 0;
	initial forever #2.5 core_clk = ~core_clk;
	ipe_unit i_ipe_unit (.core_clk(core_clk), .nrst(nrst), .ce(1'b1), .reg_sel(sel),
		.reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .ext_int_pin(4'h0),
		.slave_mode_pin(slv), .tmr_req(evt[4:2]), .dma_req(evt[1:0]), .cpu_ack(cpu_ack),
		.reg_rdata(rdata), .cpu_irq(cpu_irq), .ack_type(ack_type), .ack_valid(ack_valid),
		.dma_stop(dma_stop));
	ipe_cpu_model i_ipe_cpu_model (.core_clk(core_clk), .irq_en(irq_en), .cpu_irq(cpu_irq),
		.cpu_ack(cpu_ack));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		{sel, rd, wr, addr, wdata} = {1'b1, ~w, w, a, d};
		@(negedge core_clk);
		{sel, rd, wr} = 3'h0;
	endtask : acc
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		acc(1'b0, a, 16'h0000);
		chk($sformatf("read %h", a), exp, rdata);
	endtask : rdc
	task automatic ev(input logic [4:0] e);
		@(negedge core_clk);
		evt = e;
		@(negedge core_clk);
		evt = 5'h00;
		repeat (2) @(negedge core_clk);
	endtask : ev
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(negedge core_clk);
		nrst = 1'b1;
		rdc(8'h26, 16'h0000);
		rdc(8'h30, 16'h0000);
		rdc(8'h3e, 16'h0000);
		acc(1'b1, 8'h28, 16'h0000);
		$display("test reset done");
		ev(5'h14);
		rdc(8'h30, 16'h0005);
		rdc(8'h2e, 16'h0001);
		rdc(8'h26, 16'h8008);
		rdc(8'h26, 16'h8008);
		rdc(8'h24, 16'h8008);
		chk("ack_type", 16'h0008, {8'h00, ack_type});
		rdc(8'h30, 16'h0000);
		rdc(8'h2c, 16'h0001);
		rdc(8'h2e, 16'h0000);
		rdc(8'h24, 16'h0000);
		acc(1'b1, 8'h22, 16'h0008);
		rdc(8'h2c, 16'h0000);
		$display("test poll done");
		ev(5'h03);
		rdc(8'h24, 16'h800a);
		chk("cpu_irq", 16'h0000, {15'h0, cpu_irq});
		acc(1'b1, 8'h22, 16'h8000);
		rdc(8'h26, 16'h800b);
		irq_en = 1'b1;
		repeat (4) @(negedge core_clk);
		irq_en = 1'b0;
		chk("ack_type", 16'h000b, {8'h00, ack_type});
		rdc(8'h2c, 16'h0008);
		acc(1'b1, 8'h22, 16'h000a);
		rdc(8'h2c, 16'h0008);
		acc(1'b1, 8'h22, 16'h000b);
		rdc(8'h2c, 16'h0000);
		$display("test eoi done");
		acc(1'b1, 8'h30, 16'h8000);
		chk("dma_stop", 16'h0001, {15'h0, dma_stop});
		rdc(8'h30, 16'h8000);
		acc(1'b1, 8'h30, 16'h0000);
		chk("dma_stop", 16'h0000, {15'h0, dma_stop});
		$display("test dma done");
		slv = 1'b1;
		repeat (6) @(negedge core_clk);
		acc(1'b1, 8'h20, 16'h00a8);
		rdc(8'h20, 16'h00a8);
		ev(5'h10);
		rdc(8'h30, 16'h0004);
		rdc(8'h2e, 16'h0020);
		rdc(8'h24, 16'h0000);
		rdc(8'h2e, 16'h0020);
		irq_en = 1'b1;
		repeat (4) @(negedge core_clk);
		irq_en = 1'b0;
		chk("ack_type", 16'h00ad, {8'h00, ack_type});
		rdc(8'h30, 16'h0000);
		rdc(8'h2c, 16'h0020);
		acc(1'b1, 8'h22, 16'h8000);
		rdc(8'h2c, 16'h0020);
		acc(1'b1, 8'h22, 16'h0005);
		rdc(8'h2c, 16'h0000);
		$display("test slave done");
		finish_test();
	end
endmodule : tb_ipe_unit
